// ### rtl/hscr_regs.sv
// Purpose: host clock divider, interrupt control and status/control registers
// Assumes: APB slave, zero wait states; pins pass two flip-flops first
// Notes:   offsets are register index times four
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "hscr_cfg.svh"

// Summary of operation
// - Host clock = master clock / divider[5:0]
// - Divider resets to thirty-two
// - New modulus applies at next counter wrap
// - Interrupt bits read back pending state
// - Write one clears three irqs, sends C
// - Bits 3,2 power gain/freq DACs, reset off
// - Bit 1 drives FM receive enable
// - Status bit 7 mirrors unlock pin
// - Digital mode unlock blocks PA, TX outputs
// - Status bit 6 mirrors tx-on pin
// - Status bit 5 shows synth interface ready
// - Bit 4 enables master clock output
// - Bit 3 shows conversion done, reset one
// - Reading result registers clears conversion done
// - Bits 2,1 set aux DAC range
// - Bit 0 zero blocks PA enable
// - Offset trims are signed six-bit values
module hscr_regs
  import hscr_pkg::*;
(
  input  wire  logic                     clk,               // Master clock
  input  wire  logic                     rst,               // Sync reset, high
  input  wire  logic                     psel,              // APB select
  input  wire  logic                     penable,           // APB enable
  input  wire  logic                     pwrite,            // APB write
  input  wire  logic [11:0]              paddr,             // APB byte address
  input  wire  logic [31:0]              pwdata,            // APB write data
  output logic       [31:0]              prdata,            // APB read data
  output logic                           pready,            // APB ready
  output logic                           pslverr,           // APB error
  input  wire  logic                     synth_unlock,      // Pin, high = unlocked
  input  wire  logic                     tx_on_indicator,   // Pin, PA powered
  input  wire  logic                     synth_iface_busy,  // Synth interface busy
  input  wire  logic                     conversion_event,  // Conversion finished
  input  wire  hscr_byte_type            rssi_result,       // Signal-strength result
  input  wire  hscr_byte_type            batt_result,       // Battery result
  input  wire  logic                     irq_wb_set,        // Wide-band irq event
  input  wire  logic                     irq_f_set,         // F irq event
  input  wire  logic                     irq_d_set,         // D irq event
  input  wire  logic                     irq_c_clear,       // C irq cleared by DSP
  input  wire  logic                     digital_mode,      // Digital mode active
  input  wire  logic                     pa_request,        // PA enable request
  input  wire  hscr_trim_type            tx_i_data,         // TX I before gating
  input  wire  hscr_trim_type            tx_q_data,         // TX Q before gating
  output logic                           host_clk_en,       // Host clock pulse
  output logic                           host_clk_out,      // Host clock level
  output logic                           master_clk_out_enable, // Clock out enable
  output logic                           gain_dac_power,    // Gain DAC power
  output logic                           freq_dac_power,    // Freq DAC power
  output logic                           fm_receive_enable, // FM receive enable
  output hscr_range_type                 aux_dac_range,     // Aux DAC range
  output logic                           pa_enable_out,     // PA enable
  output logic                           tx_mute,           // TX outputs silenced
  output hscr_trim_type                  tx_i_drive,        // Gated TX I
  output hscr_trim_type                  tx_q_drive,        // Gated TX Q
  output hscr_trim_type                  tx_i_offset_trim,  // I offset, signed
  output hscr_trim_type                  tx_q_offset_trim,  // Q offset, signed
  output logic                           irq_wb_pending,    // Wide-band irq
  output logic                           irq_f_pending,     // F irq
  output logic                           irq_d_pending,     // D irq
  output logic                           irq_c_pending      // C irq
);

  function automatic logic idx_hit(input logic [11:0] a, input logic [4:0] idx);
    idx_hit = (a[1:0] == 2'h0) && (a[11:2] == {5'h00, idx});
  endfunction

  logic          unlock_meta_q;
  logic          unlock_q;
  logic          txon_meta_q;
  logic          txon_q;
  logic          busy_meta_q;
  logic          busy_q;
  logic          wr_fire;
  logic          rd_fire;
  logic          mapped;
  hscr_div_type  div_q;
  hscr_div_type  div_cnt_q;
  logic          conv_done_q;
  logic          gain_q;
  logic          freq_q;
  logic          fm_q;
  logic          mclk_en_q;
  hscr_range_type range_q;
  logic          pa_allow_q;
  hscr_trim_type ofs_i_q;
  hscr_trim_type ofs_q_q;
  logic          irq_wb_q;
  logic          irq_f_q;
  logic          irq_d_q;
  logic          irq_c_q;
  hscr_byte_type rd_d;
  logic          block_tx;
  logic          rd_setup;
  logic          wr_int;
  logic          wr_div;
  logic          wr_stat;
  logic          wr_txi;
  logic          wr_txq;
  logic          rd_result;
  hscr_div_type  div_act_q;
  logic [31:0]   prdata_q;

  // Pins cross in through two flops; only the second is read
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      unlock_meta_q <= 1'b0;
      unlock_q      <= 1'b0;
    end
    else
    begin
      unlock_meta_q <= synth_unlock;
      unlock_q      <= unlock_meta_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      txon_meta_q <= 1'b0;
      txon_q      <= 1'b0;
    end
    else
    begin
      txon_meta_q <= tx_on_indicator;
      txon_q      <= txon_meta_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy_meta_q <= 1'b0;
      busy_q      <= 1'b0;
    end
    else
    begin
      busy_meta_q <= synth_iface_busy;
      busy_q      <= busy_meta_q;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_fire = psel && penable && pwrite;
  assign rd_fire = psel && penable && !pwrite;
  assign mapped  = idx_hit(paddr, `HSCR_IDX_INT_CTRL) || idx_hit(paddr, `HSCR_IDX_CLK_DIV)
                || idx_hit(paddr, `HSCR_IDX_RSSI) || idx_hit(paddr, `HSCR_IDX_BATT)
                || idx_hit(paddr, `HSCR_IDX_STAT_CTRL) || idx_hit(paddr, `HSCR_IDX_SYN_STATUS)
                || idx_hit(paddr, `HSCR_IDX_TXI_OFS) || idx_hit(paddr, `HSCR_IDX_TXQ_OFS);

  // One write strobe per writable register and a result-read strobe, on the completing access edge; rd_setup fires in the setup cycle
  assign wr_int    = wr_fire && idx_hit(paddr, `HSCR_IDX_INT_CTRL);
  assign wr_div    = wr_fire && idx_hit(paddr, `HSCR_IDX_CLK_DIV);
  assign wr_stat   = wr_fire && idx_hit(paddr, `HSCR_IDX_STAT_CTRL);
  assign wr_txi    = wr_fire && idx_hit(paddr, `HSCR_IDX_TXI_OFS);
  assign wr_txq    = wr_fire && idx_hit(paddr, `HSCR_IDX_TXQ_OFS);
  assign rd_result = rd_fire
                  && (idx_hit(paddr, `HSCR_IDX_RSSI) || idx_hit(paddr, `HSCR_IDX_BATT));
  assign rd_setup  = psel && !penable && !pwrite;

  // Divider register, taken at the completing access edge
  always_ff @(posedge clk)
  begin
    if (rst)
      div_q <= `HSCR_RST_CLK_DIV;
    else if (wr_div)
      div_q <= pwdata[5:0];
  end

  // Divider reloads only at its own wrap, so a new modulus starts cleanly
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div_cnt_q    <= 6'h00;
      div_act_q    <= `HSCR_RST_CLK_DIV;
      host_clk_en  <= 1'b0;
      host_clk_out <= 1'b0;
    end
    else
    begin
      host_clk_en <= 1'b0;
      if (div_cnt_q == 6'h00)
      begin
        div_cnt_q   <= div_q - 6'h01;
        div_act_q   <= div_q;
        host_clk_en <= 1'b1;
      end
      else
        div_cnt_q <= div_cnt_q - 6'h01;
      // Duty follows the modulus in force, not a pending write
      host_clk_out <= (div_cnt_q >= (div_act_q >> 1));
    end
  end

  // Interrupt flags; an event wins over a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_wb_q <= 1'b0;
    else if (irq_wb_set)
      irq_wb_q <= 1'b1;
    else if (wr_int && pwdata[`HSCR_INT_CLR_WB])
      irq_wb_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      irq_f_q <= 1'b0;
    else if (irq_f_set)
      irq_f_q <= 1'b1;
    else if (wr_int && pwdata[`HSCR_INT_CLR_F])
      irq_f_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      irq_d_q <= 1'b0;
    else if (irq_d_set)
      irq_d_q <= 1'b1;
    else if (wr_int && pwdata[`HSCR_INT_CLR_D])
      irq_d_q <= 1'b0;
  end

  // Send-C from the host beats the far side's clear
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_c_q <= 1'b0;
    else if (wr_int && pwdata[`HSCR_INT_SEND_C])
      irq_c_q <= 1'b1;
    else if (irq_c_clear)
      irq_c_q <= 1'b0;
  end

  // Power and receive enables
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      gain_q <= 1'b0;
      freq_q <= 1'b0;
      fm_q   <= 1'b0;
    end
    else if (wr_int)
    begin
      gain_q <= pwdata[`HSCR_INT_GAIN_PWR];
      freq_q <= pwdata[`HSCR_INT_FREQ_PWR];
      fm_q   <= pwdata[`HSCR_INT_FM_RX];
    end
  end

  // Writable status/control fields
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mclk_en_q  <= `HSCR_RST_MCLK_EN;
      range_q    <= `HSCR_RST_RANGE;
      pa_allow_q <= 1'b0;
    end
    else if (wr_stat)
    begin
      mclk_en_q  <= pwdata[`HSCR_ST_MCLK_EN];
      range_q    <= pwdata[`HSCR_ST_RANGE_HI:`HSCR_ST_RANGE_LO];
      pa_allow_q <= pwdata[`HSCR_ST_PA_ALLOW];
    end
  end

  // Conversion done; a new result wins over the read-clear
  always_ff @(posedge clk)
  begin
    if (rst)
      conv_done_q <= `HSCR_RST_CONV_DONE;
    else if (conversion_event)
      conv_done_q <= 1'b1;
    else if (rd_result)
      conv_done_q <= 1'b0;
  end

  // Offset trims
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ofs_i_q <= `HSCR_RST_OFS;
      ofs_q_q <= `HSCR_RST_OFS;
    end
    else
    begin
      if (wr_txi)
        ofs_i_q <= pwdata[5:0];
      if (wr_txq)
        ofs_q_q <= pwdata[5:0];
    end
  end

  // Read mux; reserved and write-only bits read zero
  always_comb
  begin
    rd_d = 8'h00;
    if (idx_hit(paddr, `HSCR_IDX_INT_CTRL))
      rd_d = {irq_wb_q, irq_f_q, irq_d_q, irq_c_q, gain_q, freq_q, fm_q, 1'b0};
    else if (idx_hit(paddr, `HSCR_IDX_STAT_CTRL))
      rd_d = {unlock_q, txon_q, !busy_q, mclk_en_q, conv_done_q, range_q, pa_allow_q};
    else if (idx_hit(paddr, `HSCR_IDX_SYN_STATUS))
      rd_d = {7'h00, !busy_q};
    else if (idx_hit(paddr, `HSCR_IDX_RSSI))
      rd_d = rssi_result;
    else if (idx_hit(paddr, `HSCR_IDX_BATT))
      rd_d = batt_result;
  end

  // Read data is captured in the setup cycle so that it comes from a flop
  // and still stands for the whole zero-wait access phase
  always_ff @(posedge clk)
  begin
    if (rst)
      prdata_q <= 32'h0000_0000;
    else if (rd_setup && mapped)
      prdata_q <= {24'h00_0000, rd_d};
    else
      prdata_q <= 32'h0000_0000;
  end

  assign prdata = prdata_q;

  // Unlock in digital mode overrides every transmit enable
  assign block_tx = digital_mode && unlock_q;

  // PA enable needs a request, host permission and no digital-mode unlock
  always_ff @(posedge clk)
  begin
    if (rst)
      pa_enable_out <= 1'b0;
    else
      pa_enable_out <= pa_request && pa_allow_q && !block_tx;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tx_mute    <= 1'b1;
      tx_i_drive <= 6'h00;
      tx_q_drive <= 6'h00;
    end
    else
    begin
      tx_mute    <= block_tx;
      tx_i_drive <= block_tx ? 6'h00 : tx_i_data;
      tx_q_drive <= block_tx ? 6'h00 : tx_q_data;
    end
  end

  assign master_clk_out_enable = mclk_en_q;
  assign gain_dac_power        = gain_q;
  assign freq_dac_power        = freq_q;
  assign fm_receive_enable     = fm_q;
  assign aux_dac_range         = range_q;
  assign tx_i_offset_trim      = ofs_i_q;
  assign tx_q_offset_trim      = ofs_q_q;
  assign irq_wb_pending        = irq_wb_q;
  assign irq_f_pending         = irq_f_q;
  assign irq_d_pending         = irq_d_q;
  assign irq_c_pending         = irq_c_q;

endmodule // hscr_regs

// ### rtl/hscr_cfg.svh
// Purpose: register indices, field positions and reset values
// Assumes: APB byte addresses are four times the register index
// Notes:   definitions only
`ifndef HSCR_CFG_SVH
`define HSCR_CFG_SVH

// Register indices
`define HSCR_IDX_INT_CTRL    5'h02
`define HSCR_IDX_SYN_STATUS  5'h07
`define HSCR_IDX_CLK_DIV     5'h0a
`define HSCR_IDX_RSSI        5'h0b
`define HSCR_IDX_BATT        5'h0c
`define HSCR_IDX_STAT_CTRL   5'h0e
`define HSCR_IDX_TXI_OFS     5'h0f
`define HSCR_IDX_TXQ_OFS     5'h10

// Interrupt control fields
`define HSCR_INT_CLR_WB      7
`define HSCR_INT_CLR_F       6
`define HSCR_INT_CLR_D       5
`define HSCR_INT_SEND_C      4
`define HSCR_INT_GAIN_PWR    3
`define HSCR_INT_FREQ_PWR    2
`define HSCR_INT_FM_RX       1

// Status/control fields
`define HSCR_ST_UNLOCK       7
`define HSCR_ST_TX_ON        6
`define HSCR_ST_SYN_RDY      5
`define HSCR_ST_MCLK_EN      4
`define HSCR_ST_CONV_DONE    3
`define HSCR_ST_RANGE_HI     2
`define HSCR_ST_RANGE_LO     1
`define HSCR_ST_PA_ALLOW     0

// Reset values
`define HSCR_RST_CLK_DIV     6'h20
`define HSCR_RST_MCLK_EN     1'b1
`define HSCR_RST_CONV_DONE   1'b1
`define HSCR_RST_RANGE       2'h0
`define HSCR_RST_OFS         6'h00

`endif

// ### rtl/hscr_pkg.sv
// Purpose: shared types of the host status/control register block
// Assumes: constants come from hscr_cfg.svh
// Notes:   types only
package hscr_pkg;
  typedef logic [7:0] hscr_byte_type;
  typedef logic [5:0] hscr_div_type;
  typedef logic [5:0] hscr_trim_type;
  typedef logic [1:0] hscr_range_type;
endpackage

// ### verification/hscr_chk.sv
// Purpose: port assertions for hscr_regs
// Assumes: zero-wait APB, sync reset high
// Notes: bound at the foot of this file
`timescale 1ns/10ps
module hscr_chk
(
  input wire logic        clk,                   // Clock
  input wire logic        rst,                   // Reset
  input wire logic        psel,                  // Select
  input wire logic        penable,               // Enable
  input wire logic        pwrite,                // Write
  input wire logic [11:0] paddr,                 // Address
  input wire logic [31:0] pwdata,                // Write data
  input wire logic        pa_request,            // PA request
  input wire logic        host_clk_en,           // Host tick
  input wire logic        master_clk_out_enable, // Clock out
  input wire logic        gain_dac_power,        // Gain DAC
  input wire logic        pa_enable_out,         // PA out
  input wire logic        irq_wb_set,            // WB event
  input wire logic        irq_wb_pending,        // WB pending
  input wire logic        digital_mode,          // Digital mode
  input wire logic        synth_unlock           // Unlock pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [6:0] gap_q;
  logic       seen_q;
  logic       dwr_q;
  logic       pal_q;
  logic [1:0] ulk_q;
  wire        wr = psel && penable && pwrite;
  always_ff @(posedge clk)
    gap_q <= (rst || host_clk_en) ? 7'h00 : gap_q + 7'h01;
  // Period check only holds until software touches the divider
  always_ff @(posedge clk)
  begin
    seen_q <= !rst && (seen_q || host_clk_en);
    dwr_q  <= !rst && (dwr_q || (wr && paddr == 12'h028));
    pal_q  <= rst ? 1'b0 : (wr && paddr == 12'h038) ? pwdata[0] : pal_q;
    ulk_q  <= {ulk_q[0], synth_unlock};
  end
  sequence int_wr;
    wr && paddr == 12'h008;
  endsequence
  sequence st_wr;
    wr && paddr == 12'h038;
  endsequence
  AST_RST_VAL: assert property ($fell(rst) |-> master_clk_out_enable && !gain_dac_power)
    else $error("reset levels wrong");
  AST_GAIN_WR: assert property (int_wr |=> gain_dac_power == $past(pwdata[3]))
    else $error("gain power not written");
  AST_MCLK_WR: assert property (st_wr |=> master_clk_out_enable == $past(pwdata[4]))
    else $error("clock out enable not written");
  AST_CLR_WB: assert property (int_wr ##0 (pwdata[7] && !irq_wb_set) |=> !irq_wb_pending)
    else $error("wide-band irq not cleared");
  AST_WB_HOLD: assert property (int_wr ##0 (!pwdata[7] && irq_wb_pending) |=> irq_wb_pending)
    else $error("zero write changed irq");
  AST_PA_GATE: assert property (pa_enable_out |-> $past(pa_request) && $past(pal_q))
    else $error("PA enable without permission");
  AST_PA_LOCK: assert property (pa_enable_out |-> !$past(digital_mode && ulk_q[1]))
    else $error("PA enable while unlocked in digital mode");
  AST_HCLK_32: assert property (host_clk_en && seen_q && !dwr_q |-> gap_q == 7'h1f)
    else $error("host clock period not 32");
  AST_HCLK_GAP: assert property (host_clk_en |=> !host_clk_en)
    else $error("host clock ticks back to back");
endmodule // hscr_chk

bind hscr_regs hscr_chk u_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pa_request, .host_clk_en, .master_clk_out_enable, .gain_dac_power, .pa_enable_out,
  .irq_wb_set, .irq_wb_pending, .digital_mode, .synth_unlock);

// ### verification/hscr_host.sv
// Purpose: host controller model, APB master
// Assumes: slave may insert wait states
// Notes: released bus shows inverted values
`timescale 1ns/10ps
module hscr_host
(
  output logic             psel,    // Select
  output logic             penable, // Enable
  output logic             pwrite,  // Direction
  output logic [11:0]      paddr,   // Byte address
  output logic [31:0]      pwdata,  // Write data
  input  wire logic        clk,     // Clock
  input  wire logic [31:0] prdata,  // Read data
  input  wire logic        pready   // Ready
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule // hscr_host

// ### verification/test_host_status_control_regs.sv
// Purpose: self-checking bench for hscr_regs
// Assumes: host model drives APB
// Notes: fixed stimulus only
`timescale 1ns/10ps
module test_host_status_control_regs;
  import hscr_pkg::*;
  logic           clk = 1'b0, rst = 1'b1, psel, penable, pwrite, pready;
  logic [11:0]    paddr;
  logic [31:0]    pwdata, prdata, q, n, h;
  logic           pslverr, host_clk_out, tx_mute, irq_wb_pending, irq_f_pending;
  logic           irq_d_pending, irq_c_pending;
  hscr_trim_type  tx_q_drive;
  logic           synth_unlock = 0, tx_on_indicator = 0, synth_iface_busy = 0;
  logic           conversion_event = 0, irq_wb_set = 0, irq_f_set = 0, irq_d_set = 0;
  logic           digital_mode = 0, pa_request = 0, host_clk_en, master_clk_out_enable;
  logic           gain_dac_power, freq_dac_power, fm_receive_enable, pa_enable_out;
  hscr_range_type aux_dac_range;
  hscr_trim_type  tx_i_data = 6'h15, tx_q_data = 6'h2a, tx_i_drive, tx_i_offset_trim;
  hscr_trim_type  tx_q_offset_trim;
  int             err_count = 0, n_tests = 0;
  hscr_regs uut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .synth_unlock, .tx_on_indicator, .synth_iface_busy, .conversion_event,
    .rssi_result(8'h5a), .batt_result(8'ha5), .irq_wb_set, .irq_f_set, .irq_d_set,
    .irq_c_clear(1'b0), .digital_mode, .pa_request, .tx_i_data, .tx_q_data, .host_clk_en,
    .host_clk_out, .master_clk_out_enable, .gain_dac_power, .freq_dac_power,
    .fm_receive_enable, .aux_dac_range, .pa_enable_out, .tx_mute, .tx_i_drive,
    .tx_q_drive, .tx_i_offset_trim, .tx_q_offset_trim, .irq_wb_pending,
    .irq_f_pending, .irq_d_pending, .irq_c_pending);
  hscr_host u_host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready);
  always #2.5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    u_host.acc(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.acc(1'b1, a, d, q);
  endtask
  // Edges from one host tick to the next
  task automatic per;
    @(posedge clk);
    while (host_clk_en !== 1'b1)
      @(posedge clk);
    n = 0;
    h = 0;
    do
    begin
      @(posedge clk);
      n++;
      h = h + 32'(host_clk_out);
    end
    while (host_clk_en !== 1'b1);
  endtask
  task automatic t_reset;
    rc(12'h008, 32'h0000_0000);
    rc(12'h038, 32'h0000_0038);
    rc(12'h028, 32'h0000_0000);
    rc(12'h044, 32'h0000_0000);
    chk(32'({pslverr, gain_dac_power, freq_dac_power, fm_receive_enable,
             master_clk_out_enable}), 1);
    per;
    chk(n, 32);
    chk(h, 16);
  endtask
  task automatic t_rerst;
    wr(12'h008, 32'h0000_0008);
    wr(12'h038, 32'h0000_0000);
    rc(12'h008, 32'h0000_0018);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rc(12'h008, 32'h0000_0000);
    rc(12'h038, 32'h0000_0038);
  endtask
  task automatic t_div(input logic [31:0] d, input logic [31:0] exp);
    wr(12'h028, d);
    per;
    per;
    chk(n, exp);
  endtask
  task automatic t_irq;
    @(posedge clk);
    {irq_wb_set, irq_f_set, irq_d_set} <= 3'h7;
    @(posedge clk);
    {irq_wb_set, irq_f_set, irq_d_set} <= 3'h0;
    rc(12'h008, 32'h0000_00e0);
    wr(12'h008, 32'h0000_000e);
    rc(12'h008, 32'h0000_00ee);
    chk(32'({irq_wb_pending, irq_f_pending, irq_d_pending, irq_c_pending,
             gain_dac_power, freq_dac_power, fm_receive_enable}), 32'h0000_0077);
    wr(12'h008, 32'h0000_00f0);
    rc(12'h008, 32'h0000_0010);
  endtask
  task automatic t_stat;
    {synth_unlock, tx_on_indicator, synth_iface_busy} <= 3'h7;
    wr(12'h038, 32'h0000_00e7);
    rc(12'h038, 32'h0000_00cf);
    chk(32'({master_clk_out_enable, aux_dac_range}), 3);
    rc(12'h02c, 32'h0000_005a);
    rc(12'h038, 32'h0000_00c7);
    conversion_event <= 1'b1;
    @(posedge clk);
    conversion_event <= 1'b0;
    rc(12'h038, 32'h0000_00cf);
    rc(12'h030, 32'h0000_00a5);
    rc(12'h038, 32'h0000_00c7);
    rc(12'h01c, 32'h0000_0000);
    {tx_on_indicator, synth_iface_busy} <= 2'h0;
    repeat (3) @(posedge clk);
    rc(12'h038, 32'h0000_00a7);
    rc(12'h01c, 32'h0000_0001);
  endtask
  task automatic t_pa;
    {digital_mode, pa_request} <= 2'h3;
    repeat (4) @(posedge clk);
    chk(32'({pa_enable_out, tx_mute, tx_i_drive, tx_q_drive}), 32'h0000_1000);
    digital_mode <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'({pa_enable_out, tx_mute, tx_i_drive, tx_q_drive}), 32'h0000_256a);
    wr(12'h038, 32'h0000_0010);
    repeat (2) @(posedge clk);
    chk(32'(pa_enable_out), 0);
    wr(12'h03c, 32'h0000_00ff);
    wr(12'h040, 32'h0000_00a0);
    @(posedge clk);
    chk(32'({tx_i_offset_trim, tx_q_offset_trim}), 32'h0000_0fe0);
  endtask
  task automatic test_done;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_div(32'h0000_00c5, 5);
    t_div(32'h0000_0002, 2);
    t_div(32'h0000_0020, 32);
    t_irq;
    t_rerst;
    t_stat;
    t_pa;
    test_done;
  end
  initial
  begin
    #50000;
    err_count++;
    test_done;
  end
endmodule // test_host_status_control_regs
